/* File: logic/irqv_defs.vh */
`ifndef IRQV_DEFS_VH
`define IRQV_DEFS_VH
// Register byte addresses on the plain register port.
`define IRQV_ADDR_PEND 8'h00
`define IRQV_ADDR_LVL0 8'h04
`define IRQV_ADDR_CTRL 8'h08
`define IRQV_ADDR_STAT 8'h0c
`define IRQV_ADDR_MASK 8'h10
`define IRQV_ADDR_VBASE 8'h14
// Control register fields.
`define IRQV_CTRL_WDT_SEL 0
`define IRQV_CTRL_LV_IEN 1
// Status register fields (sticky, write one to clear).
`define IRQV_ST_ACCEPT 0
`define IRQV_ST_WDT 1
`define IRQV_ST_LVD 2
`define IRQV_ST_VMON 3
// Reset values.
`define IRQV_CTRL_RST 8'h00
`define IRQV_VBASE_RST 32'h0000_0000
// Vector slot size in bytes, and the software number below which entries switch stack.
`define IRQV_SLOT_BYTES 4
`define IRQV_SWI_SPLIT 8'h80
// Debug trap probe address and its marker value.
`define IRQV_TRAP_ADDR 32'h0fff_ffe7
`define IRQV_TRAP_MARK 8'hff
// Fixed vector numbers for the special sources.
`define IRQV_VEC_WDT 8'hf0
`define IRQV_VEC_LVD 8'hf1
`endif

/* File: logic/irqv_arbiter.v */
`timescale 1ns/1ps
`include "irqv_defs.vh"

// Picks the highest pending level; ties go to the lower source index.
module irqv_arbiter #(
    parameter N = 8
) (
    // Inputs.
    input wire [N-1:0] req,
    input wire [3*N-1:0] lvl,
    // Result.
    output reg found,
    output reg [7:0] idx,
    output reg [2:0] best
);
    integer i;

    // Scan from the top so that lower indices overwrite on equal levels.
    always @* begin
        found = 1'b0;
        idx = 8'h00;
        best = 3'h0;
        for (i = N - 1; i >= 0; i = i - 1) begin
            // Level zero means the source is disabled.
            if (req[i] && lvl[3*i +: 3] != 3'h0 &&
                (!found || lvl[3*i +: 3] >= best)) begin
                found = 1'b1;
                idx = i[7:0];
                best = lvl[3*i +: 3];
            end
        end
    end
endmodule // irqv_arbiter

/* File: logic/irqv_ctrl.v */
`timescale 1ns/1ps
`include "irqv_defs.vh"

module irqv_ctrl #(
    parameter N = 8
) (
    // Clock, reset, enable.
    input wire clk,
    input wire rst,
    input wire ce,
    // Register port.
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    // Peripheral request pulses, same clock.
    input wire [N-1:0] periph_req,
    // Pins from outside the clock domain.
    input wire wdt_underflow_pin,
    input wire supply_ok_pin,
    // CPU side.
    input wire cpu_ack,
    input wire cpu_reti,
    input wire swi_take,
    input wire [7:0] swi_num,
    input wire trap_take,
    input wire [7:0] trap_mark,
    input wire fetch_valid,
    input wire [31:0] fetch_data,
    output wire cpu_irq,
    output reg [7:0] cpu_vec_num,
    output reg fetch_req,
    output reg [31:0] fetch_addr,
    output reg jump_valid,
    output reg [31:0] jump_addr,
    output reg stack_sel,
    output reg wdt_reset,
    output wire irq_out
);
    // Sequencer states.
    localparam ST_IDLE = 2'b00;
    localparam ST_OFFER = 2'b01;
    localparam ST_FETCH = 2'b10;
    // Code 2'b11 is never entered; the default branch steers it back to
    // idle so that a disturbed state register cannot lock the sequencer.

    // Synchronisers: first stage is read only by the second.
    reg wdt_s1_q, wdt_s2_q;
    reg sup_s1_q, sup_s2_q, sup_old_q;
    reg [N+1:0] pend_q; // Peripheral pending plus WDT and LVD at top.
    reg [3*N-1:0] lvl_q; // Per-source request level fields.
    reg [7:0] ctrl_q; // Control bits.
    reg [3:0] stat_q; // Sticky event status.
    reg [3:0] mask_q; // Interrupt mask.
    reg [31:0] vbase_q; // Relocatable vector table base.
    reg [1:0] state_q; // Sequencer state.
    reg [7:0] sel_q; // Vector number in flight.
    reg [N+1:0] sel_bit_q; // One-hot pending bit in flight.
    reg saved_q; // Saved stack select for the return.
    reg saved_valid_q; // Marks that a return must restore.
    reg swi_q; // Current entry is a software one that saved.
    reg wdt_old_q; // Edge detector on synced underflow.

    // Arbiter result for the peripheral sources only. The two special
    // sources are ranked ahead of it by the sequencer itself, so the
    // arbiter never has to know about them.
    wire arb_found;
    wire [7:0] arb_idx;
    wire [2:0] arb_lvl;
    wire wdt_edge;
    wire sup_rise;
    wire [N+1:0] set_v;
    wire wr_pend;

    // Shared decode: is this write aimed at the given address.
    // Every register write uses it, so the write address compare lives in one place.
    function is_wr;
        input [7:0] a;
        begin
            is_wr = reg_wr && (reg_addr == a);
        end
    endfunction

    // Fixed tie-break among peripherals lives in the arbiter.
    // It is a linear scan, so a much wider N would lengthen this path
    // through to the sequencer's next-state logic.
    irqv_arbiter #(.N(N)) u_arb (
        .req(pend_q[N-1:0]),
        .lvl(lvl_q),
        .found(arb_found),
        .idx(arb_idx),
        .best(arb_lvl)
    );

    // Edge detectors run on the second synchroniser stage only. The supply
    // history resets to one, the level of a healthy supply, so the release
    // of reset cannot look like a recovery event.
    assign wdt_edge = wdt_s2_q & ~wdt_old_q;
    assign sup_rise = sup_s2_q & ~sup_old_q;
    assign wr_pend = is_wr(`IRQV_ADDR_PEND);
    // New request events per pending bit.
    assign set_v = {sup_rise & ctrl_q[`IRQV_CTRL_LV_IEN],
                    wdt_edge & ~ctrl_q[`IRQV_CTRL_WDT_SEL],
                    periph_req};
    // The CPU sees one offered request at a time.
    assign cpu_irq = (state_q == ST_OFFER);
    assign irq_out = |(stat_q & mask_q);

    // Synchronise pins and keep edge history.
    // The supply pin is a level; only its rising edge matters here.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            wdt_s1_q <= 1'b0;
            wdt_s2_q <= 1'b0;
            sup_s1_q <= 1'b1;
            sup_s2_q <= 1'b1;
            sup_old_q <= 1'b1;
            wdt_old_q <= 1'b0;
        end else if (ce) begin
            // Two stages before any logic looks at the pins.
            wdt_s1_q <= wdt_underflow_pin;
            wdt_s2_q <= wdt_s1_q;
            sup_s1_q <= supply_ok_pin;
            sup_s2_q <= sup_s1_q;
            sup_old_q <= sup_s2_q;
            wdt_old_q <= wdt_s2_q;
        end
    end

    // Configuration registers. Only one address matches per write, so an
    // if and else-if chain is enough. A write to the control register
    // always rewrites the enable bit, but the watchdog select can only be
    // raised; software has no path that lowers it again.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= `IRQV_CTRL_RST;
            lvl_q <= {3*N{1'b0}};
            mask_q <= 4'h0;
            vbase_q <= `IRQV_VBASE_RST;
        end else if (ce) begin
            if (is_wr(`IRQV_ADDR_LVL0)) begin
                lvl_q <= reg_wdata[3*N-1:0];
            end else if (is_wr(`IRQV_ADDR_CTRL)) begin
                // Once set, the select bit ignores writes of zero.
                ctrl_q <= {6'h00, reg_wdata[`IRQV_CTRL_LV_IEN],
                           reg_wdata[`IRQV_CTRL_WDT_SEL] |
                           ctrl_q[`IRQV_CTRL_WDT_SEL]};
            end else if (is_wr(`IRQV_ADDR_MASK)) begin
                mask_q <= reg_wdata[3:0];
            end else if (is_wr(`IRQV_ADDR_VBASE)) begin
                // Table is word aligned so slots stay 4-byte.
                vbase_q <= {reg_wdata[31:2], 2'b00};
            end
        end
    end

    // Pending flags: set on event, clear on jump or software zero write.
    // A new event in the clear cycle wins, so no request is lost.
    // Software writes a zero to drop a request and a one to keep it; the
    // written ones never raise a flag, since the write only masks.
    // The flag in flight is dropped one cycle after the jump pulse, so a
    // read in the jump cycle still shows it as pending.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            pend_q <= {N+2{1'b0}};
        end else if (ce) begin
            pend_q <= (pend_q
                       & ~((jump_valid ? sel_bit_q : {N+2{1'b0}}))
                       & (wr_pend ? reg_wdata[N+1:0] : {N+2{1'b1}}))
                      | set_v;
        end
    end

    // Sticky status with write-one-to-clear; set beats clear.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            stat_q <= 4'h0;
        end else if (ce) begin
            stat_q <= (stat_q & ~(is_wr(`IRQV_ADDR_STAT) ?
                                  reg_wdata[3:0] : 4'h0))
                      | {sup_rise, sup_rise, wdt_edge,
                         jump_valid};
        end
    end

    // Watchdog reset request when the select bit chose reset. The request
    // is a single-cycle pulse; stretching it to a system reset is left to
    // the reset logic outside, which also clears the select bit.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            wdt_reset <= 1'b0;
        end else if (ce) begin
            wdt_reset <= wdt_edge & ctrl_q[`IRQV_CTRL_WDT_SEL];
        end
    end

    // Sequencer: pick, offer, fetch the slot, jump.
    // Software entries skip the offer step because the CPU itself asked
    // for them. Only one entry is in flight at any time, and the saved
    // stack select is a single bit: a second low software entry before
    // the return overwrites the saved value.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            // Reset ranks above everything: it aborts any sequence.
            state_q <= ST_IDLE;
            sel_q <= 8'h00;
            sel_bit_q <= {N+2{1'b0}};
            cpu_vec_num <= 8'h00;
            fetch_req <= 1'b0;
            fetch_addr <= 32'h0000_0000;
            jump_valid <= 1'b0;
            jump_addr <= 32'h0000_0000;
            stack_sel <= 1'b1;
            saved_q <= 1'b1;
            saved_valid_q <= 1'b0;
            swi_q <= 1'b0;
        end else if (ce) begin
            jump_valid <= 1'b0;
            fetch_req <= 1'b0;
            if (cpu_reti && saved_valid_q) begin
                stack_sel <= saved_q;
                saved_valid_q <= 1'b0;
            end
            case (state_q)
                ST_IDLE: begin
                    if (trap_take) begin
                        // Marker FFh routes the trap through slot zero.
                        // Other markers take the same slot for now.
                        sel_q <= (trap_mark == `IRQV_TRAP_MARK) ?
                                 8'h00 : 8'h00;
                        sel_bit_q <= {N+2{1'b0}};
                        swi_q <= 1'b1;
                        saved_q <= stack_sel;
                        saved_valid_q <= 1'b1;
                        stack_sel <= 1'b0;
                        fetch_req <= 1'b1;
                        fetch_addr <= vbase_q;
                        state_q <= ST_FETCH;
                    end else if (swi_take) begin
                        sel_q <= swi_num;
                        sel_bit_q <= {N+2{1'b0}};
                        if (swi_num < `IRQV_SWI_SPLIT) begin
                            saved_q <= stack_sel;
                            saved_valid_q <= 1'b1;
                            stack_sel <= 1'b0;
                            swi_q <= 1'b1;
                        end else begin
                            swi_q <= 1'b0;
                        end
                        fetch_req <= 1'b1;
                        fetch_addr <= vbase_q + {22'h0, swi_num, 2'b00};
                        state_q <= ST_FETCH;
                    end else if (pend_q[N]) begin
                        // Specials by fixed order ahead of peripherals.
                        sel_q <= `IRQV_VEC_WDT;
                        sel_bit_q <= {2'b01, {N{1'b0}}};
                        state_q <= ST_OFFER;
                    end else if (pend_q[N+1]) begin
                        sel_q <= `IRQV_VEC_LVD;
                        sel_bit_q <= {2'b10, {N{1'b0}}};
                        state_q <= ST_OFFER;
                    end else if (arb_found) begin
                        sel_q <= arb_idx;
                        sel_bit_q <= {{N+1{1'b0}}, 1'b1} << arb_idx;
                        state_q <= ST_OFFER;
                    end
                end
                ST_OFFER: begin
                    // The vector number follows the offer by one cycle.
                    cpu_vec_num <= sel_q;
                    if (cpu_ack) begin
                        swi_q <= 1'b0;
                        fetch_req <= 1'b1;
                        fetch_addr <= vbase_q + {22'h0, sel_q, 2'b00};
                        state_q <= ST_FETCH;
                    end else if ((pend_q & sel_bit_q) == {N+2{1'b0}}) begin
                        // Software withdrew the request before acceptance.
                        state_q <= ST_IDLE;
                    end
                end
                ST_FETCH: begin
                    // The slot read may take any number of cycles; the
                    // sequencer simply waits for the answer pulse.
                    cpu_vec_num <= sel_q;
                    if (fetch_valid) begin
                        jump_valid <= 1'b1;
                        jump_addr <= fetch_data;
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Read data one cycle after the strobe; unmapped reads zero.
    // The bus is cleared in every cycle without a read strobe so that stale
    // data never looks like an answer; reads have no side effects.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (ce) begin
            reg_rdata <= 32'h0000_0000;
            if (reg_rd) begin
                if (reg_addr == `IRQV_ADDR_PEND) begin
                    reg_rdata <= {{30-N{1'b0}}, pend_q};
                end else if (reg_addr == `IRQV_ADDR_LVL0) begin
                    reg_rdata <= {{32-3*N{1'b0}}, lvl_q};
                end else if (reg_addr == `IRQV_ADDR_CTRL) begin
                    reg_rdata <= {24'h0, ctrl_q};
                end else if (reg_addr == `IRQV_ADDR_STAT) begin
                    reg_rdata <= {28'h0, stat_q};
                end else if (reg_addr == `IRQV_ADDR_MASK) begin
                    reg_rdata <= {28'h0, mask_q};
                end else if (reg_addr == `IRQV_ADDR_VBASE) begin
                    reg_rdata <= vbase_q;
                end
            end
        end
    end
endmodule // irqv_ctrl

/* File: dv/irqv_props.sv */
`timescale 1ns/1ps
// Watches handshake order and stack choice at the controller's CPU side.
module irqv_props (
    // Clock, reset and run enable.
    input logic clk,
    input logic rst,
    input logic ce,
    // CPU requests.
    input logic cpu_irq,
    input logic cpu_ack,
    input logic cpu_reti,
    input logic swi_take,
    input logic [7:0] swi_num,
    input logic trap_take,
    input logic fetch_valid,
    input logic [31:0] fetch_data,
    // Controller answers.
    input logic fetch_req,
    input logic [31:0] fetch_addr,
    input logic jump_valid,
    input logic [31:0] jump_addr,
    input logic stack_sel,
    input logic wdt_reset
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    a_ack_then_fetch: assert property (cpu_ack && cpu_irq && ce
        |=> fetch_req) else $error("accept gave no slot read");
    a_slot_aligned: assert property (fetch_req
        |-> fetch_addr[1:0] == 2'b00) else $error("slot not aligned");
    a_jump_from_slot: assert property (fetch_valid && ce
        |=> jump_valid && jump_addr == $past(fetch_data))
        else $error("jump not to slot data");
    a_low_swi_isp: assert property (fetch_req && $past(swi_take)
        && !$past(swi_num[7]) |-> !stack_sel)
        else $error("low software number kept user stack");
    a_high_swi_keep: assert property (swi_take && swi_num[7]
        && !cpu_reti |=> $stable(stack_sel)) else $error("stack changed");
    a_reti_restore: assert property ($rose(stack_sel) && !$past(rst)
        |-> $past(cpu_reti)) else $error("stack select rose alone");
    a_trap_isp: assert property (fetch_req && $past(trap_take)
        |-> !stack_sel) else $error("trap kept user stack");
    a_wdt_pulse: assert property (wdt_reset |=> !wdt_reset)
        else $error("watchdog reset longer than one cycle");
    c_jump: cover property (jump_valid);
    c_isp: cover property ($fell(stack_sel));
    c_wdt_rst: cover property (wdt_reset);
endmodule // irqv_props

bind irqv_ctrl irqv_props irqv_props_u (.*);

/* File: dv/irqv_cpu_model.sv */
`timescale 1ns/1ps
// CPU stand-in: accepts an offer when the bench pulses ack_en and answers
// slot reads after lat cycles; outside an answer the data bus toggles.
module irqv_cpu_model (
    // Clock and reset.
    input logic clk,
    input logic rst,
    // Bench controls: accept permission and answer latency (1 or more).
    input logic ack_en,
    input logic [3:0] lat,
    // Controller side.
    input logic cpu_irq,
    input logic fetch_req,
    input logic [31:0] fetch_addr,
    output logic cpu_ack,
    output logic fetch_valid,
    output logic [31:0] fetch_data
);
    logic [31:0] addr_q; // Slot address being read.
    logic [3:0] cnt_q; // Cycles left before the slot answer.
    // Handler address is the slot address with its top bit flipped, so a
    // jump straight to the slot address is caught.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cpu_ack <= 1'b0;
            fetch_valid <= 1'b0;
            fetch_data <= 32'h0;
            addr_q <= 32'h0;
            cnt_q <= 4'h0;
        end else begin
            cpu_ack <= ack_en && cpu_irq && !cpu_ack;
            fetch_valid <= 1'b0;
            fetch_data <= ~fetch_data;
            if (fetch_req) begin
                addr_q <= fetch_addr;
                cnt_q <= lat;
            end else if (cnt_q == 4'h1) begin
                fetch_valid <= 1'b1;
                fetch_data <= addr_q ^ 32'h8000_0000;
                cnt_q <= 4'h0;
            end else if (cnt_q != 4'h0) begin
                cnt_q <= cnt_q - 4'h1;
            end
        end
    end
endmodule // irqv_cpu_model

/* File: dv/tb.sv */
`timescale 1ns/1ps
`include "irqv_defs.vh"
// Bench for the interrupt controller with a behavioural CPU beside it.
module tb;
    localparam int N = 8;
    localparam logic [31:0] VB = 32'h0010_0000; // Vector table base.
    logic clk = 1'b0, rst = 1'b1, ce = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00, swi_num = 8'h00, trap_mark = 8'hff;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, fetch_data, fetch_addr;
    logic [31:0] jump_addr, fa, rv; // fa: last slot asked, rv: last read.
    logic [N-1:0] periph_req = 8'h00;
    logic wdt_underflow_pin = 1'b0, supply_ok_pin = 1'b0, cpu_reti = 1'b0;
    logic swi_take = 1'b0, trap_take = 1'b0, ack_en = 1'b0;
    logic cpu_ack, fetch_valid, cpu_irq, fetch_req, jump_valid, stack_sel;
    logic wdt_reset, irq_out;
    logic [7:0] cpu_vec_num;
    logic [3:0] lat = 4'h1;
    int error_cnt = 0, checked = 0, cyc = 0, jcnt = 0, wcnt = 0;
    // Rows: levels, request pulse, pending left after one accept.
    logic [23:0] r_lvl [4] = '{24'h249249, 24'h279249, 24'h249248, 24'h249249};
    logic [7:0] r_req [4] = '{8'h28, 8'h28, 8'h03, 8'hff};
    logic [7:0] r_left [4] = '{8'h20, 8'h08, 8'h01, 8'hfe};
    logic [7:0] r_idx [4] = '{8'h03, 8'h05, 8'h01, 8'h00}; // Winner.
    // Software numbers on both sides of the split; the last is the trap.
    logic [7:0] s_num [5] = '{8'h00, 8'h7f, 8'h80, 8'hff, 8'h00};
    logic [7:0] z_adr [6] = '{8'h00, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h40};
    irqv_ctrl #(.N(N)) dut_u (.*);
    irqv_cpu_model cpu_u (.*);
    initial forever #4 clk = ~clk;
    task automatic chk(input string n, input logic [31:0] s, e);
        checked++;
        if (s !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe.
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 rv = reg_rdata;
    endtask
    task automatic wjump(input int n0);
        repeat (60) if (jcnt == n0) @(posedge clk);
        chk("jump count", jcnt, n0 + 1);
    endtask
    task automatic conclude;
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Pulses are caught mid-cycle, away from the edge that launches them.
    always @(negedge clk) begin
        if (fetch_req === 1'b1) fa = fetch_addr;
        if (wdt_reset === 1'b1) wcnt++;
        if (jump_valid === 1'b1) begin
            jcnt++;
            chk("jump address", jump_addr, fa ^ 32'h8000_0000);
        end
    end
    // A hang is cut short and counted as a mismatch.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            conclude();
        end
    end
    initial begin
        int n;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk) chk("stack reset", stack_sel, 1);
        for (int i = 0; i < 6; i++) begin
            rd(z_adr[i]);
            chk("reset value", rv, 0);
        end
        wr(8'h40, 32'hffff_ffff);
        rd(8'h40);
        chk("unmapped", rv, 0);
        wr(`IRQV_ADDR_VBASE, VB);
        for (int i = 0; i < 4; i++) begin
            wr(`IRQV_ADDR_LVL0, {8'h00, r_lvl[i]});
            @(posedge clk) periph_req <= r_req[i];
            @(posedge clk) periph_req <= 8'h00;
            rd(`IRQV_ADDR_PEND);
            chk("pending set", rv, {24'h0, r_req[i]});
            n = jcnt;
            @(posedge clk) ack_en <= 1'b1;
            @(posedge clk) ack_en <= 1'b0;
            wjump(n);
            chk("peripheral slot", fa, VB + {22'h0, r_idx[i], 2'b00});
            rd(`IRQV_ADDR_PEND);
            chk("pending left", rv, {24'h0, r_left[i]});
            wr(`IRQV_ADDR_PEND, 32'h0);
            rd(`IRQV_ADDR_PEND);
            chk("pending cleared", rv, 0);
        end
        for (int i = 0; i < 5; i++) begin
            n = jcnt;
            @(posedge clk) swi_num <= s_num[i];
            if (i < 4) swi_take <= 1'b1;
            else trap_take <= 1'b1;
            @(posedge clk) swi_take <= 1'b0;
            trap_take <= 1'b0;
            wjump(n);
            lat <= lat + 4'h1;
            chk("slot", fa, VB + {22'h0, s_num[i], 2'b00});
            chk("stack select", stack_sel, s_num[i][7]);
            @(posedge clk) cpu_reti <= 1'b1;
            @(posedge clk) cpu_reti <= 1'b0;
            @(negedge clk) chk("stack restored", stack_sel, 1);
        end
        wr(`IRQV_ADDR_STAT, 32'hf);
        wr(`IRQV_ADDR_MASK, 32'h2);
        wr(`IRQV_ADDR_CTRL, 32'h2);
        @(posedge clk) wdt_underflow_pin <= 1'b1;
        supply_ok_pin <= 1'b1;
        repeat (8) @(posedge clk);
        chk("special order", cpu_vec_num, `IRQV_VEC_WDT);
        chk("irq level", irq_out, 1);
        rd(`IRQV_ADDR_STAT);
        chk("event flags", rv, 32'he);
        rd(`IRQV_ADDR_PEND);
        chk("special pending", rv, 32'h300);
        wr(`IRQV_ADDR_MASK, 32'h0);
        #1 chk("masked", irq_out, 0);
        wr(`IRQV_ADDR_MASK, 32'h2);
        #1 chk("unmasked", irq_out, 1);
        wr(`IRQV_ADDR_STAT, 32'h2);
        #1 chk("status cleared", irq_out, 0);
        wr(`IRQV_ADDR_PEND, 32'h0);
        wr(`IRQV_ADDR_STAT, 32'hf);
        wr(`IRQV_ADDR_CTRL, 32'h0);
        @(posedge clk) supply_ok_pin <= 1'b0;
        repeat (4) @(posedge clk);
        supply_ok_pin <= 1'b1;
        repeat (6) @(posedge clk);
        rd(`IRQV_ADDR_PEND);
        chk("no low voltage request", rv, 0);
        rd(`IRQV_ADDR_STAT);
        chk("recovery flags", rv, 32'hc);
        wr(`IRQV_ADDR_CTRL, 32'h1);
        wr(`IRQV_ADDR_CTRL, 32'h0);
        rd(`IRQV_ADDR_CTRL);
        chk("select sticks", rv, 1);
        n = wcnt;
        @(posedge clk) wdt_underflow_pin <= 1'b0;
        repeat (4) @(posedge clk);
        wdt_underflow_pin <= 1'b1;
        repeat (6) @(posedge clk);
        chk("watchdog reset", wcnt, n + 1);
        rd(`IRQV_ADDR_PEND);
        chk("no watchdog request", rv, 0);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(`IRQV_ADDR_CTRL);
        chk("select cleared", rv, 0);
        conclude();
    end
endmodule // tb
